// ### src/nvs_map.svh
/*
  register offsets, field positions, reset values and fixed
  storage addresses of the nvm status and parameter load block.
  assumes byte offsets on an 8-bit register address port.
*/
`ifndef NVS_MAP_SVH
`define NVS_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define NVS_OFS_STAT      8'h08
`define NVS_OFS_RDAT      8'h0a
`define NVS_OFS_SRDAT     8'h0e
`define NVS_OFS_SF        8'h12
`define NVS_OFS_IRQ_STAT  8'h14
`define NVS_OFS_IRQ_MASK  8'h18

// ****************************************
// field positions
// ****************************************
`define NVS_STAT_DONE     0
`define NVS_STAT_VPOK     1
`define NVS_SF_PARAM_SET_LOAD_TRIGGER   0
`define NVS_SF_TUNE_KICK  1
`define NVS_SF_SEL_LO     5
`define NVS_SF_SEL_HI     6
`define NVS_IRQ_PROG      0
`define NVS_IRQ_READ      1
`define NVS_IRQ_OPS       2
`define NVS_IRQ_TUNE      3
`define NVS_IRQ_W         4

// ****************************************
// reset values and fixed addresses
// ****************************************
`define NVS_STAT_RST      16'h0000
`define NVS_SF_RST        8'h00
`define NVS_IRQ_RST       4'h0
`define NVS_ADDR_SPECIAL  11'h400
`define NVS_ADDR_TUNE     11'h004

`endif

// ### src/nvs_pkg.sv
/*
  types of the nvm status and parameter load block.
  assumes nothing of its surroundings.
*/
package nvs_pkg;

  // parameter set select encoding, in field order 00..11
  typedef enum logic [1:0] {
    NVS_SET_SHORT,
    NVS_SET_TIGHT,
    NVS_SET_DEFAULT,
    NVS_SET_RSVD
  } nvs_set_e;

  // sequencer states
  typedef enum logic [2:0] {
    NVS_S_BOOT,
    NVS_S_SPECIAL,
    NVS_S_AUTO,
    NVS_S_IDLE,
    NVS_S_READ,
    NVS_S_OPS,
    NVS_S_TUNE
  } nvs_state_e;

endpackage

// ### src/nvs_fetch.sv
/*
  single word fetch engine toward the nonvolatile array.
  assumes the array answers a held request with a one-cycle ack
  and its data in that same cycle, all on clk.
*/
`timescale 1ns/10ps

module nvs_fetch #(
  parameter int AW = 11,
  parameter int DW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic [AW-1:0] start_addr,
  output logic               mem_req,
  output logic      [AW-1:0] mem_addr,
  input  wire logic          mem_ack,
  input  wire logic [DW-1:0] mem_rdata,
  output logic               done,
  output logic      [DW-1:0] data
);

  // ****************************************
  // request and capture
  // ****************************************
  logic          req_q;   // request held to the array
  logic [AW-1:0] addr_q;  // latched word address
  logic          done_q;  // one-cycle completion pulse
  logic [DW-1:0] data_q;  // captured word
  wire           take = req_q & mem_ack;

  // start is honoured only while no request is open
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q  <= 1'b0;
      addr_q <= '0;
      done_q <= 1'b0;
      data_q <= '0;
    end else begin
      req_q  <= (req_q & ~mem_ack) | (start & ~req_q);
      addr_q <= (start & ~req_q) ? start_addr : addr_q;
      done_q <= take;
      data_q <= take ? mem_rdata : data_q;
    end
  end

  assign mem_req  = req_q;
  assign mem_addr = addr_q;
  assign done     = done_q;
  assign data     = data_q;

endmodule // nvs_fetch

// ### src/nvs_top.sv
/*
  status, read data, special word and special function registers
  of the on-chip nonvolatile memory interface, with the loads of
  receiver parameter sets and the regulator tuning value.
  assumes a plain register port on clk, a same-clock programming
  sequencer, nonvolatile array and parameter set loader, and two
  level pins (supply comparator, retained wake option) from
  outside the clock domain.
*/
`timescale 1ns/10ps
`include "nvs_map.svh"

module nvs_top
  import nvs_pkg::*;
#(
  parameter int TUNE_W = 32
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              prog_done_evt,
  input  wire logic              vpp_ok_pin,
  input  wire logic              read_start,
  input  wire logic [10:0]       read_addr,
  input  wire logic              sleep_exit,
  input  wire logic              wake_load_short_preamble_set,
  output logic                   nvm_req,
  output logic      [10:0]       nvm_addr,
  input  wire logic              nvm_ack,
  input  wire logic [31:0]       nvm_rdata,
  output logic                   param_set_load_req,
  output logic      [1:0]        param_set_load_sel,
  input  wire logic              param_set_load_ack,
  output logic      [TUNE_W-1:0] regulator_tune_reg,
  output logic                   busy,
  output logic                   irq
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (TUNE_W < 1 || TUNE_W > 32) begin : g_bad_w
    $error("nvs_top: TUNE_W must lie in 1..32");
  end

  // ****************************************
  // declarations
  // ****************************************
  nvs_state_e        state_q;       // sequencer state
  nvs_state_e        state_d;       // its next value
  logic              done_q;        // program done flag
  logic              done_d;
  logic              vpp_meta_q;    // supply comparator, first stage
  logic              vpp_sync_q;    // supply comparator, usable
  logic              wake_meta_q;   // wake option, first stage
  logic              wake_sync_q;   // wake option, usable
  logic [31:0]       rdat_q;        // read data register
  logic [31:0]       srdat_q;       // special word register
  logic [31:0]       srdat_d;
  logic [7:0]        sf_q;          // special function register
  logic [7:0]        sf_d;
  logic [1:0]        kick_clr;      // trigger clear strobes
  logic [1:0]        kick_set;      // trigger set strobes
  logic              read_pend_q;   // read request waiting
  logic [10:0]       read_addr_q;   // its word address
  logic              auto_pend_q;   // wake load waiting
  logic              ops_req_q;     // load request to set loader
  logic              ops_go;        // open a set load
  nvs_set_e          param_set_select_q;     // set being loaded
  nvs_set_e          param_set_select_d;
  nvs_set_e          auto_sel;      // set chosen at reset or wake
  nvs_set_e          host_sel;      // set in the select field
  logic              fetch_go;      // open a word fetch
  logic [10:0]       fetch_a;       // its address
  logic              fetch_done;    // word fetch finished
  logic [31:0]       fetch_data;    // fetched word
  logic [TUNE_W-1:0] tune_q;        // regulator tuning value
  logic [3:0]        irq_stat_q;    // sticky events
  logic [3:0]        irq_stat_d;
  logic [3:0]        irq_mask_q;    // event enables
  logic [3:0]        ev;            // this cycle's events
  logic [31:0]       rdata_q;       // read data register of bus
  logic [31:0]       rdata_d;
  logic              busy_q;
  logic              irq_q;
  localparam logic [15:0] STAT_RST = `NVS_STAT_RST; // status reset

  // ****************************************
  // register decode
  // ****************************************
  wire hit_stat  = reg_addr == `NVS_OFS_STAT;
  wire hit_rdat  = reg_addr == `NVS_OFS_RDAT;
  wire hit_srdat = reg_addr == `NVS_OFS_SRDAT;
  wire hit_sf    = reg_addr == `NVS_OFS_SF;
  wire hit_ist   = reg_addr == `NVS_OFS_IRQ_STAT;
  wire hit_imk   = reg_addr == `NVS_OFS_IRQ_MASK;
  wire wr_stat   = reg_wr & hit_stat;
  wire wr_srdat  = reg_wr & hit_srdat;
  wire wr_sf     = reg_wr & hit_sf;
  wire wr_ist    = reg_wr & hit_ist;
  wire wr_imk    = reg_wr & hit_imk;
  wire rd_stat   = reg_rd & hit_stat;
  wire rd_sf     = reg_rd & hit_sf;

  // status view: only the two flags, other bits read zero
  wire [15:0] stat_view = {14'h0000, vpp_sync_q, done_q};

  // ****************************************
  // program status
  // ****************************************
  // sticky done flag, write one clears, set wins
  assign done_d = prog_done_evt |
                  (done_q & ~(wr_stat & reg_wdata[`NVS_STAT_DONE]));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= STAT_RST[`NVS_STAT_DONE];
    end else begin
      done_q <= done_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vpp_meta_q  <= 1'b0;
      vpp_sync_q  <= 1'b0;
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      vpp_meta_q  <= vpp_ok_pin;
      vpp_sync_q  <= vpp_meta_q;
      wake_meta_q <= wake_load_short_preamble_set;
      wake_sync_q <= wake_meta_q;
    end
  end

  // ****************************************
  // special function register
  // ****************************************
  assign host_sel = nvs_set_e'(sf_q[`NVS_SF_SEL_HI:`NVS_SF_SEL_LO]);
  // writing zero never cancels a pending trigger
  assign kick_set = wr_sf ? reg_wdata[1:0] : 2'b00;

  always_comb begin
    sf_d = `NVS_SF_RST;
    sf_d[`NVS_SF_SEL_HI:`NVS_SF_SEL_LO] =
      wr_sf ? reg_wdata[`NVS_SF_SEL_HI:`NVS_SF_SEL_LO]
            : sf_q[`NVS_SF_SEL_HI:`NVS_SF_SEL_LO];
    sf_d[1:0] = (sf_q[1:0] & ~kick_clr) | kick_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sf_q <= `NVS_SF_RST;
    end else begin
      sf_q <= sf_d;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // wake option picks short or default
  // tight is never an automatic choice
  assign auto_sel = wake_sync_q ? NVS_SET_SHORT : NVS_SET_DEFAULT;

  // one load or fetch at a time; wake, read, set, tuning order
  always_comb begin
    state_d   = state_q;
    fetch_go  = 1'b0;
    fetch_a   = `NVS_ADDR_TUNE;
    ops_go    = 1'b0;
    param_set_select_d = param_set_select_q;
    kick_clr  = 2'b00;
    case (state_q)
      NVS_S_BOOT: begin
        state_d  = NVS_S_SPECIAL;
        fetch_go = 1'b1;
        fetch_a  = `NVS_ADDR_SPECIAL;
      end
      // reset load follows the special word
      NVS_S_SPECIAL: begin
        if (fetch_done) begin
          state_d   = NVS_S_AUTO;
          ops_go    = 1'b1;
          param_set_select_d = auto_sel;
        end
      end
      NVS_S_IDLE: begin
        if (auto_pend_q) begin
          state_d   = NVS_S_AUTO;
          ops_go    = 1'b1;
          param_set_select_d = auto_sel;
        end else if (read_pend_q) begin
          state_d  = NVS_S_READ;
          fetch_go = 1'b1;
          fetch_a  = read_addr_q;
        end else if (sf_q[`NVS_SF_PARAM_SET_LOAD_TRIGGER]) begin
          if (host_sel == NVS_SET_RSVD) begin
            kick_clr[`NVS_SF_PARAM_SET_LOAD_TRIGGER] = 1'b1;
          end else begin
            // host load of the selected set
            // select field passed as the set code
            state_d   = NVS_S_OPS;
            ops_go    = 1'b1;
            param_set_select_d = host_sel;
          end
        end else if (sf_q[`NVS_SF_TUNE_KICK]) begin
          // tuning word at its fixed address
          state_d  = NVS_S_TUNE;
          fetch_go = 1'b1;
          fetch_a  = `NVS_ADDR_TUNE;
        end
      end
      NVS_S_AUTO, NVS_S_OPS: begin
        if (param_set_load_ack) begin
          state_d = NVS_S_IDLE;
          kick_clr[`NVS_SF_PARAM_SET_LOAD_TRIGGER] = state_q == NVS_S_OPS;
        end
      end
      NVS_S_READ, NVS_S_TUNE: begin
        if (fetch_done) begin
          state_d = NVS_S_IDLE;
          kick_clr[`NVS_SF_TUNE_KICK] = state_q == NVS_S_TUNE;
        end
      end
      default: begin
        state_d = NVS_S_IDLE;
      end
    endcase
  end

  // state and load request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= NVS_S_BOOT;
      ops_req_q <= 1'b0;
      param_set_select_q <= NVS_SET_DEFAULT;
    end else begin
      state_q   <= state_d;
      ops_req_q <= ops_go | (ops_req_q & ~param_set_load_ack);
      param_set_select_q <= param_set_select_d;
    end
  end

  // pending read and wake requests, set wins over take
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_pend_q <= 1'b0;
      read_addr_q <= 11'h000;
      auto_pend_q <= 1'b0;
    end else begin
      read_pend_q <= read_start |
                     (read_pend_q & ~(state_d == NVS_S_READ &
                                      state_q == NVS_S_IDLE));
      read_addr_q <= read_start ? read_addr : read_addr_q;
      auto_pend_q <= sleep_exit |
                     (auto_pend_q & ~(state_d == NVS_S_AUTO &
                                      state_q == NVS_S_IDLE));
    end
  end

  // word fetch engine
  nvs_fetch #(
    .AW (11),
    .DW (32)
  ) u_fetch (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (fetch_go),
    .start_addr (fetch_a),
    .mem_req    (nvm_req),
    .mem_addr   (nvm_addr),
    .mem_ack    (nvm_ack),
    .mem_rdata  (nvm_rdata),
    .done       (fetch_done),
    .data       (fetch_data)
  );

  // ****************************************
  // data registers
  // ****************************************
  wire read_land = fetch_done & (state_q == NVS_S_READ);
  wire spec_land = fetch_done & (state_q == NVS_S_SPECIAL);
  wire tune_land = fetch_done & (state_q == NVS_S_TUNE);

  // power up word, software may overwrite it
  assign srdat_d = spec_land ? fetch_data :
                   wr_srdat  ? reg_wdata  : srdat_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdat_q  <= 32'h0000_0000;
      srdat_q <= 32'h0000_0000;
      tune_q  <= '0;
    end else begin
      rdat_q  <= read_land ? fetch_data : rdat_q;
      srdat_q <= srdat_d;
      tune_q  <= tune_land ? fetch_data[TUNE_W-1:0] : tune_q;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign ev[`NVS_IRQ_PROG] = prog_done_evt;
  assign ev[`NVS_IRQ_READ] = read_land;
  assign ev[`NVS_IRQ_OPS]  = ops_req_q & param_set_load_ack;
  assign ev[`NVS_IRQ_TUNE] = tune_land;

  // sticky per event, write one clears, set wins
  for (genvar i = 0; i < `NVS_IRQ_W; i++) begin : g_irq
    assign irq_stat_d[i] = ev[i] |
                           (irq_stat_q[i] & ~(wr_ist & reg_wdata[i]));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= `NVS_IRQ_RST;
      irq_mask_q <= `NVS_IRQ_RST;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= wr_imk ? reg_wdata[3:0] : irq_mask_q;
      irq_q      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // data only in the cycle after a read, zero elsewhere
  assign rdata_d =
    !reg_rd   ? 32'h0000_0000 :
    hit_stat  ? {16'h0000, stat_view} :
    hit_rdat  ? rdat_q :
    hit_srdat ? srdat_q :
    hit_sf    ? {24'h00_0000, sf_q} :
    hit_ist   ? {28'h000_0000, irq_stat_q} :
    hit_imk   ? {28'h000_0000, irq_mask_q} :
                32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
      busy_q  <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      busy_q  <= state_d != NVS_S_IDLE;
    end
  end

  assign reg_rdata          = rdata_q;
  assign param_set_load_req = ops_req_q;
  assign param_set_load_sel = param_set_select_q;
  assign regulator_tune_reg = tune_q;
  assign busy               = busy_q;
  assign irq                = irq_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_host_go;
    state_q == NVS_S_IDLE && !auto_pend_q && !read_pend_q &&
    sf_q[`NVS_SF_PARAM_SET_LOAD_TRIGGER] && host_sel != NVS_SET_RSVD;
  endsequence

  sequence s_ops_done;
    state_q == NVS_S_OPS && param_set_load_ack;
  endsequence

  chk_done_sticky: assert property (
    prog_done_evt |=> done_q)
    else $error("program done flag not set");

  chk_vpok_sync: assert property (
    vpp_ok_pin [*3] |=> vpp_sync_q)
    else $error("supply ok not reported");

  chk_stat_reserved: assert property (
    rd_stat |=> reg_rdata[31:2] == 30'h0000_0000)
    else $error("status reserved bits not zero");

  chk_read_land: assert property (
    read_land |=> rdat_q == $past(fetch_data))
    else $error("read data not captured");

  chk_special_addr: assert property (
    state_q == NVS_S_SPECIAL && nvm_req |->
      nvm_addr == `NVS_ADDR_SPECIAL)
    else $error("special word address wrong");

  chk_ops_start: assert property (
    s_host_go |=> param_set_load_req &&
      param_set_load_sel == $past(host_sel))
    else $error("set load not started");

  chk_tune_addr: assert property (
    state_q == NVS_S_TUNE && nvm_req |->
      nvm_addr == `NVS_ADDR_TUNE)
    else $error("tuning address wrong");

  chk_sf_reserved: assert property (
    rd_sf |=> reg_rdata[31:7] == 25'h000_0000 &&
      reg_rdata[4:2] == 3'h0)
    else $error("sf reserved bits not zero");

  chk_auto_set: assert property (
    state_q == NVS_S_AUTO && param_set_load_req |->
      param_set_load_sel != NVS_SET_TIGHT)
    else $error("tight set loaded automatically");

  chk_kick_clear: assert property (
    s_ops_done ##0 !(wr_sf && reg_wdata[0]) |=>
      !sf_q[`NVS_SF_PARAM_SET_LOAD_TRIGGER])
    else $error("set trigger not cleared");

endmodule // nvs_top

// ### verif/nvs_top_tb_top.sv
/*
  self-checking bench of the nvm status and parameter load block.
  assumes nvs_pkg and nvs_map.svh are compiled beside it; the bench
  stands in for the array, the set loader and the register master.
*/
`timescale 1ns/10ps
`include "nvs_map.svh"

module nvs_top_tb_top
  import nvs_pkg::*;
;
  // ****************************************
  // signals and scoreboard queues
  // ****************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        prog_done_evt = 1'b0;
  logic        vpp_ok_pin = 1'b1;
  logic        read_start = 1'b0;
  logic [10:0] read_addr = 11'h000;
  logic        sleep_exit = 1'b0;
  logic        wake_opt = 1'b0;
  logic        nvm_req;
  logic [10:0] nvm_addr;
  logic        nvm_ack = 1'b0;
  logic [31:0] nvm_rdata = 32'h0000_0000;
  logic        ps_req;
  logic [1:0]  ps_sel;
  logic        ps_ack = 1'b0;
  logic [31:0] tune;
  logic        busy;
  logic        irq;
  logic        rd_d = 1'b0;
  int          seed = 1;
  int          failures = 0;
  int          n_checks = 0;
  logic [31:0] exp_q[$];
  string       nam_q[$];
  logic [10:0] addr_q[$];
  logic [1:0]  sel_q[$];

  always #10 clk = ~clk;

  nvs_top uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prog_done_evt(prog_done_evt),
    .vpp_ok_pin(vpp_ok_pin), .read_start(read_start),
    .read_addr(read_addr), .sleep_exit(sleep_exit),
    .wake_load_short_preamble_set(wake_opt), .nvm_req(nvm_req),
    .nvm_addr(nvm_addr), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata),
    .param_set_load_req(ps_req), .param_set_load_sel(ps_sel),
    .param_set_load_ack(ps_ack), .regulator_tune_reg(tune),
    .busy(busy), .irq(irq)
  );

  // ****************************************
  // helpers
  // ****************************************
  // array contents made from the address
  function automatic logic [31:0] mem_word(input logic [10:0] a);
    return {a, 10'h2a5, ~a};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // register write, one strobe cycle then a gap
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // register read, expectation noted for the monitor
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    exp_q.push_back(e);
    nam_q.push_back(nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // let the sequencer start, then wait for idle under a bound
  task automatic wait_idle();
    int i;
    repeat (3) @(posedge clk);
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
    check("busy", {31'h0, busy}, 32'h0);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // one-cycle pulse: program done (0) or sleep exit (1)
  task automatic pulse_event(input bit wake);
    if (wake) begin
      sleep_exit <= 1'b1;
    end else begin
      prog_done_evt <= 1'b1;
    end
    @(posedge clk);
    sleep_exit <= 1'b0;
    prog_done_evt <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ****************************************
  // monitor: read data one cycle after the strobe
  // ****************************************
  always @(posedge clk) begin
    if (rd_d) begin
      check(nam_q.pop_front(), reg_rdata, exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end

  // ****************************************
  // array stand-in, answers after a random wait
  // ****************************************
  initial forever begin
    int d;
    @(posedge clk);
    if (nvm_req === 1'b1) begin
      check("nvm_addr", {21'h0, nvm_addr},
            {21'h0, addr_q.pop_front()});
      d = $unsigned($random(seed)) % 4;
      repeat (d) @(posedge clk);
      nvm_ack <= 1'b1;
      nvm_rdata <= mem_word(nvm_addr);
      @(posedge clk);
      nvm_ack <= 1'b0;
      nvm_rdata <= $random(seed);
    end
  end

  // ****************************************
  // set loader stand-in
  // ****************************************
  initial forever begin
    int d;
    @(posedge clk);
    if (ps_req === 1'b1) begin
      check("set_sel", {30'h0, ps_sel},
            {30'h0, sel_q.pop_front()});
      d = $unsigned($random(seed)) % 5;
      repeat (d) @(posedge clk);
      ps_ack <= 1'b1;
      @(posedge clk);
      ps_ack <= 1'b0;
    end
  end

  initial begin
    #(20 * 20000);
    failures++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [10:0] a;
    int s;
    addr_q.push_back(`NVS_ADDR_SPECIAL);
    sel_q.push_back(NVS_SET_DEFAULT);
    do_reset();
    wait_idle();
    rd("special", `NVS_OFS_SRDAT, mem_word(`NVS_ADDR_SPECIAL));
    rd("status", `NVS_OFS_STAT, 32'h0000_0002);
    rd("sf", `NVS_OFS_SF, 32'h0000_0000);
    rd("irq_stat", `NVS_OFS_IRQ_STAT, 32'h0000_0004);
    wr(`NVS_OFS_IRQ_STAT, 32'h0000_000f);
    // program done, unmasked, then cleared
    wr(`NVS_OFS_IRQ_MASK, 32'h0000_0001);
    pulse_event(1'b0);
    check("irq_on", {31'h0, irq}, 32'h1);
    rd("status_done", `NVS_OFS_STAT, 32'h0000_0003);
    wr(`NVS_OFS_STAT, 32'h0000_ffff);
    wr(`NVS_OFS_IRQ_STAT, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check("irq_off", {31'h0, irq}, 32'h0);
    vpp_ok_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rd("status_low", `NVS_OFS_STAT, 32'h0000_0000);
    // masked read fetch at a random address
    a = 11'($random(seed));
    addr_q.push_back(a);
    read_start <= 1'b1;
    read_addr <= a;
    @(posedge clk);
    read_start <= 1'b0;
    read_addr <= ~a;
    wait_idle();
    check("irq_mask", {31'h0, irq}, 32'h0);
    rd("rdat", `NVS_OFS_RDAT, mem_word(a));
    wr(`NVS_OFS_RDAT, 32'h0000_0000);
    rd("rdat_ro", `NVS_OFS_RDAT, mem_word(a));
    wr(8'h40, 32'hffff_ffff);
    rd("unmapped", 8'h40, 32'h0000_0000);
    // host loads of every legal set
    for (s = 0; s < 3; s++) begin
      sel_q.push_back(s[1:0]);
      wr(`NVS_OFS_SF, {25'h0, s[1:0], 5'h01});
      wait_idle();
      rd("sf_clr", `NVS_OFS_SF, {25'h0, s[1:0], 5'h00});
    end
    // random legal select; the reserved code is never written
    s = $unsigned($random(seed)) % 3;
    sel_q.push_back(s[1:0]);
    wr(`NVS_OFS_SF, {25'h0, s[1:0], 5'h01});
    wait_idle();
    rd("sf_rand", `NVS_OFS_SF, {25'h0, s[1:0], 5'h00});
    // tuning load from the fixed address
    addr_q.push_back(`NVS_ADDR_TUNE);
    wr(`NVS_OFS_SF, 32'h0000_0002);
    wait_idle();
    check("tune", tune, mem_word(`NVS_ADDR_TUNE));
    rd("sf_tune", `NVS_OFS_SF, 32'h0000_0000);
    rd("irq_all", `NVS_OFS_IRQ_STAT, 32'h0000_000e);
    // second reset with the wake option set
    wake_opt <= 1'b1;
    addr_q.push_back(`NVS_ADDR_SPECIAL);
    sel_q.push_back(NVS_SET_SHORT);
    do_reset();
    wait_idle();
    rd("sf_rst", `NVS_OFS_SF, 32'h0000_0000);
    sel_q.push_back(NVS_SET_SHORT);
    pulse_event(1'b1);
    wait_idle();
    wake_opt <= 1'b0;
    repeat (4) @(posedge clk);
    sel_q.push_back(NVS_SET_DEFAULT);
    pulse_event(1'b1);
    wait_idle();
    check("left_sets", sel_q.size() + addr_q.size(), 32'h0);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule // nvs_top_tb_top
